// ### common/exec_pkg.sv
`default_nettype none
package exec_pkg;
  localparam int DATA_W = 32;
  localparam int IMM_W = 9;
  localparam int PRIO_W = 8;
  localparam int LINK_W = 20;
  typedef enum logic [3:0] {
    OP_NONE                = 4'h0,
    OP_ACCUM_SIGNED_A      = 4'h1,
    OP_ACCUM_ACCUM_SIGNED_A_UNSIGNED = 4'h2,
    OP_ACCUM_OR_LESS_SIGNED = 4'h3,
    OP_ACCUM_OR_LESS_UNSIGNED = 4'h4,
    OP_ACCUM_OR_NOT_EQUAL  = 4'h5,
    OP_BIT_OR              = 4'h6,
    OP_OR_NOT              = 4'h7,
    OP_BIT_OR_NOT          = 4'h8,
    OP_FUNC_RETURN         = 4'h9,
    OP_EXC_RETURN          = 4'hA,
    OP_RESTORE_LOWER       = 4'hB,
    OP_RESET_OVERFLOW      = 4'hC,
    OP_RSUB                = 4'hD,
    OP_RSUB_SAT_SIGNED     = 4'hE,
    OP_RSUB_SAT_UNSIGNED   = 4'hF
  } op_type;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [31:0] SAT_SMAX = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_SMIN = 32'h8000_0000;
  localparam logic [31:0] SAT_UMIN = 32'h0000_0000;
endpackage : exec_pkg
`default_nettype wire

// ### src/accum_exec.sv
// Summary of operation
// - Signed GE ORed into bit 0
// - Unsigned GE ORed into bit 0
// - Signed LT ORed into bit 0
// - Unsigned LT, immediate zero extended
// - Not equal ORed, immediate sign extended
// - Bit OR into bit 0, rest cleared
// - A OR NOT B, immediate zero extended
// - Bit A OR NOT bit B
// - Return traps on zero depth, else jumps
// - Exception return traps on nonzero depth
// - Exception return restores priority and enable
// - Exception return jumps, restores upper context
// - Restore lower context from link pointer
// - Clear all four overflow flags
// - Immediate minus source, no saturation
// - Short form negates source in place
// - Saturating reverse subtract, signed or unsigned
`timescale 1ns/10ps
`default_nettype none
module accum_exec #(
  parameter int DEPTH_W = 7
) (
  input  wire logic                            clock,
  input  wire logic                            rstn,
  input  wire logic                            op_valid,
  input  wire exec_pkg::op_type                op,
  input  wire logic                            use_imm,
  input  wire logic                            short_form,
  input  wire logic [exec_pkg::IMM_W-1:0]      imm9_operand,
  input  wire logic [exec_pkg::DATA_W-1:0]     src_a,
  input  wire logic [exec_pkg::DATA_W-1:0]     src_b,
  input  wire logic [exec_pkg::DATA_W-1:0]     dest_old,
  input  wire logic [4:0]                      pos1,
  input  wire logic [4:0]                      pos2,
  input  wire logic [DEPTH_W-1:0]              call_depth,
  input  wire logic [exec_pkg::DATA_W-1:0]     return_address_reg,
  input  wire logic [exec_pkg::PRIO_W-1:0]     previous_cpu_priority,
  input  wire logic                            previous_int_enable,
  input  wire logic [exec_pkg::LINK_W-1:0]     context_link_pointer,
  input  wire logic                            overflow_in,
  input  wire logic                            sticky_overflow_in,
  input  wire logic                            advance_overflow_in,
  input  wire logic                            sticky_advance_in,
  output var  logic [exec_pkg::DATA_W-1:0]     result_q,
  output var  logic                            result_we_q,
  output var  logic                            flags_we_q,
  output var  logic                            overflow_flag_q,
  output var  logic                            sticky_overflow_flag_q,
  output var  logic                            advance_overflow_flag_q,
  output var  logic                            sticky_advance_overflow_flag_q,
  output var  logic                            pc_we_q,
  output var  logic [exec_pkg::DATA_W-1:0]     pc_q,
  output var  logic                            restore_upper_q,
  output var  logic                            restore_status_word_q,
  output var  logic                            restore_lower_q,
  output var  logic [exec_pkg::LINK_W-1:0]     restore_link_q,
  output var  logic                            interrupt_control_we_q,
  output var  logic [exec_pkg::PRIO_W-1:0]     current_cpu_priority_q,
  output var  logic                            global_int_enable_q,
  output var  logic                            call_depth_underflow_trap_q,
  output var  logic                            nesting_error_trap_q
);
  logic [31:0] imm_s;
  logic [31:0] imm_z;
  logic [31:0] opb_s;
  logic [31:0] opb_z;
  logic [31:0] sub_min;
  logic [32:0] diff;
  logic        sov;
  logic        uov;
  logic        depth_zero;
  logic [31:0] result_d;
  logic        result_we_d;
  logic        flags_we_d;
  logic        ov_d;
  logic        sov_d;
  logic        adv_d;
  logic        sadv_d;
  logic        pc_we_d;
  logic [31:0] pc_d;
  logic        ru_d;
  logic        rs_d;
  logic        rl_d;
  logic [exec_pkg::LINK_W-1:0] link_d;
  logic        int_ctrl_we_d;
  logic [exec_pkg::PRIO_W-1:0] prio_d;
  logic        int_en_d;
  logic        underflow_d;
  logic        nesting_error_trap_d;
  function automatic logic [31:0] bit0_or(input logic [31:0] old, input logic cond);
    bit0_or = {old[31:1], old[0] | cond};
  endfunction : bit0_or
  always_comb begin
    imm_s = {{(32-exec_pkg::IMM_W){imm9_operand[exec_pkg::IMM_W-1]}}, imm9_operand};
    imm_z = {{(32-exec_pkg::IMM_W){1'b0}}, imm9_operand};
    opb_s = use_imm ? imm_s : src_b;
    opb_z = use_imm ? imm_z : src_b;
    if (short_form) begin
      sub_min = 32'h0000_0000;
    end else if (op == exec_pkg::OP_RSUB_SAT_UNSIGNED) begin
      sub_min = imm_z;
    end else begin
      sub_min = imm_s;
    end
    diff = {1'b0, sub_min} - {1'b0, src_a};
    sov = (sub_min[31] != src_a[31]) && (diff[31] != sub_min[31]);
    uov = diff[32];
    depth_zero = (call_depth == '0);
  end
  always_comb begin
    result_d      = result_q;
    result_we_d   = 1'b0;
    flags_we_d    = 1'b0;
    ov_d          = overflow_in;
    sov_d         = sticky_overflow_in;
    adv_d         = advance_overflow_in;
    sadv_d        = sticky_advance_in;
    pc_we_d       = 1'b0;
    pc_d          = pc_q;
    ru_d          = 1'b0;
    rs_d          = 1'b0;
    rl_d          = 1'b0;
    link_d        = restore_link_q;
    int_ctrl_we_d = 1'b0;
    prio_d        = current_cpu_priority_q;
    int_en_d      = global_int_enable_q;
    underflow_d   = 1'b0;
    nesting_error_trap_d      = 1'b0;
    if (op_valid) begin
      unique case (op)
        exec_pkg::OP_NONE: begin
        end
        exec_pkg::OP_ACCUM_SIGNED_A: begin
          result_d    = bit0_or(dest_old, $signed(src_a) >= $signed(opb_s));
          result_we_d = 1'b1;
        end
        exec_pkg::OP_ACCUM_ACCUM_SIGNED_A_UNSIGNED: begin
          result_d    = bit0_or(dest_old, src_a >= opb_z);
          result_we_d = 1'b1;
        end
        exec_pkg::OP_ACCUM_OR_LESS_SIGNED: begin
          result_d    = bit0_or(dest_old, $signed(src_a) < $signed(opb_s));
          result_we_d = 1'b1;
        end
        exec_pkg::OP_ACCUM_OR_LESS_UNSIGNED: begin
          result_d    = bit0_or(dest_old, src_a < opb_z);
          result_we_d = 1'b1;
        end
        exec_pkg::OP_ACCUM_OR_NOT_EQUAL: begin
          result_d    = bit0_or(dest_old, src_a != opb_s);
          result_we_d = 1'b1;
        end
        exec_pkg::OP_BIT_OR: begin
          result_d    = {31'h0000_0000, src_a[pos1] | src_b[pos2]};
          result_we_d = 1'b1;
        end
        exec_pkg::OP_OR_NOT: begin
          result_d    = src_a | ~opb_z;
          result_we_d = 1'b1;
        end
        exec_pkg::OP_BIT_OR_NOT: begin
          result_d    = {31'h0000_0000, src_a[pos1] | ~src_b[pos2]};
          result_we_d = 1'b1;
        end
        exec_pkg::OP_FUNC_RETURN: begin
          if (depth_zero) begin
            underflow_d = 1'b1;
          end else begin
            pc_we_d = 1'b1;
            pc_d    = return_address_reg;
            ru_d    = 1'b1;
          end
        end
        exec_pkg::OP_EXC_RETURN: begin
          if (!depth_zero) begin
            nesting_error_trap_d = 1'b1;
          end else begin
            int_ctrl_we_d = 1'b1;
            prio_d        = previous_cpu_priority;
            int_en_d      = previous_int_enable;
            pc_we_d  = 1'b1;
            pc_d     = return_address_reg;
            ru_d     = 1'b1;
            rs_d     = 1'b1;
          end
        end
        exec_pkg::OP_RESTORE_LOWER: begin
          rl_d   = 1'b1;
          link_d = context_link_pointer;
        end
        exec_pkg::OP_RESET_OVERFLOW: begin
          flags_we_d = 1'b1;
          ov_d  = 1'b0;
          sov_d = 1'b0;
          adv_d  = 1'b0;
          sadv_d = 1'b0;
        end
        exec_pkg::OP_RSUB, exec_pkg::OP_RSUB_SAT_SIGNED, exec_pkg::OP_RSUB_SAT_UNSIGNED: begin
          result_we_d = 1'b1;
          flags_we_d  = 1'b1;
          if (op == exec_pkg::OP_RSUB_SAT_SIGNED) begin
            ov_d = sov;
            if (sov) begin
              result_d = sub_min[31] ? exec_pkg::SAT_SMIN : exec_pkg::SAT_SMAX;
            end else begin
              result_d = diff[31:0];
            end
          end else if (op == exec_pkg::OP_RSUB_SAT_UNSIGNED) begin
            ov_d     = uov;
            result_d = uov ? exec_pkg::SAT_UMIN : diff[31:0];
          end else begin
            ov_d     = sov;
            result_d = diff[31:0];
          end
          adv_d  = result_d[31] ^ result_d[30];
          sov_d  = sticky_overflow_in | ov_d;
          sadv_d = sticky_advance_in | adv_d;
        end
      endcase
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_q                       <= exec_pkg::RESULT_RESET;
      result_we_q                    <= 1'b0;
      flags_we_q                     <= 1'b0;
      overflow_flag_q                <= 1'b0;
      sticky_overflow_flag_q         <= 1'b0;
      advance_overflow_flag_q        <= 1'b0;
      sticky_advance_overflow_flag_q <= 1'b0;
      pc_we_q                        <= 1'b0;
      pc_q                           <= exec_pkg::RESULT_RESET;
      restore_upper_q                <= 1'b0;
      restore_status_word_q          <= 1'b0;
      restore_lower_q                <= 1'b0;
      restore_link_q                 <= '0;
      interrupt_control_we_q         <= 1'b0;
      current_cpu_priority_q         <= '0;
      global_int_enable_q            <= 1'b0;
      call_depth_underflow_trap_q    <= 1'b0;
      nesting_error_trap_q           <= 1'b0;
    end else begin
      result_q                       <= result_d;
      result_we_q                    <= result_we_d;
      flags_we_q                     <= flags_we_d;
      overflow_flag_q                <= ov_d;
      sticky_overflow_flag_q         <= sov_d;
      advance_overflow_flag_q        <= adv_d;
      sticky_advance_overflow_flag_q <= sadv_d;
      pc_we_q                        <= pc_we_d;
      pc_q                           <= pc_d;
      restore_upper_q                <= ru_d;
      restore_status_word_q          <= rs_d;
      restore_lower_q                <= rl_d;
      restore_link_q                 <= link_d;
      interrupt_control_we_q         <= int_ctrl_we_d;
      current_cpu_priority_q         <= prio_d;
      global_int_enable_q            <= int_en_d;
      call_depth_underflow_trap_q    <= underflow_d;
      nesting_error_trap_q           <= nesting_error_trap_d;
    end
  end

  property p_ge_signed;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op == exec_pkg::OP_ACCUM_SIGNED_A) |=>
        result_we_q && result_q[31:1] == $past(dest_old[31:1]) &&
        result_q[0] == ($past(dest_old[0]) | ($signed($past(src_a)) >= $signed($past(opb_s))));
  endproperty
  a_ge_signed: assert property (p_ge_signed) else $error("signed ge wrong");

  property p_lt_unsigned;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op == exec_pkg::OP_ACCUM_OR_LESS_UNSIGNED) |=>
        result_q[0] == ($past(dest_old[0]) | ($past(src_a) < $past(opb_z)));
  endproperty
  a_lt_unsigned: assert property (p_lt_unsigned) else $error("unsigned lt wrong");

  property p_bit_or;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op == exec_pkg::OP_BIT_OR) |=> result_q[31:1] == 31'h0000_0000;
  endproperty
  a_bit_or: assert property (p_bit_or) else $error("bit or upper bits set");

  property p_orn;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op == exec_pkg::OP_OR_NOT) |=> result_q == ($past(src_a) | ~$past(opb_z));
  endproperty
  a_orn: assert property (p_orn) else $error("or not wrong");

  property p_ret_trap;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op == exec_pkg::OP_FUNC_RETURN && depth_zero) |=>
        call_depth_underflow_trap_q && !pc_we_q && !restore_upper_q;
  endproperty
  a_ret_trap: assert property (p_ret_trap) else $error("return trap missing");

  property p_rfe_trap;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op == exec_pkg::OP_EXC_RETURN && !depth_zero) |=>
        nesting_error_trap_q && !interrupt_control_we_q && !pc_we_q;
  endproperty
  a_rfe_trap: assert property (p_rfe_trap) else $error("nesting trap missing");

  property p_rfe_restore;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op == exec_pkg::OP_EXC_RETURN && depth_zero) |=>
        interrupt_control_we_q && current_cpu_priority_q == $past(previous_cpu_priority) &&
        global_int_enable_q == $past(previous_int_enable) && pc_q == $past(return_address_reg);
  endproperty
  a_rfe_restore: assert property (p_rfe_restore) else $error("exception return restore wrong");

  property p_rstv;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op == exec_pkg::OP_RESET_OVERFLOW) |=>
        flags_we_q && !overflow_flag_q && !sticky_overflow_flag_q &&
        !advance_overflow_flag_q && !sticky_advance_overflow_flag_q;
  endproperty
  a_rstv: assert property (p_rstv) else $error("overflow flags not cleared");

  property p_rsub;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op == exec_pkg::OP_RSUB && !short_form) |=>
        result_q == $past(imm_s) - $past(src_a);
  endproperty
  a_rsub: assert property (p_rsub) else $error("reverse subtract wrong");

  property p_logic_no_flags;
    @(posedge clock) disable iff (!rstn)
      (op_valid && op inside {exec_pkg::OP_ACCUM_SIGNED_A, exec_pkg::OP_OR_NOT,
                              exec_pkg::OP_BIT_OR}) |=> !flags_we_q;
  endproperty
  a_logic_no_flags: assert property (p_logic_no_flags) else $error("flags touched");

endmodule : accum_exec
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                 clock = 1'b0;
  logic                 rstn = 1'b0;
  logic                 op_valid = 1'b0;
  exec_pkg::op_type     op = exec_pkg::OP_NONE;
  logic                 use_imm = 1'b0;
  logic                 short_form = 1'b0;
  logic [8:0]           imm9_operand = 9'h000;
  logic [31:0]          src_a = 32'h0;
  logic [31:0]          src_b = 32'h0;
  logic [31:0]          dest_old = 32'h0;
  logic [4:0]           pos1 = 5'h00;
  logic [4:0]           pos2 = 5'h00;
  logic [6:0]           call_depth = 7'h00;
  logic [31:0]          return_address_reg = 32'h0;
  logic [7:0]           previous_cpu_priority = 8'h00;
  logic                 previous_int_enable = 1'b0;
  logic [19:0]          context_link_pointer = 20'h0;
  logic                 ovf_in = 1'b0;
  logic                 sov_in = 1'b0;
  logic                 aov_in = 1'b0;
  logic                 sadv_in = 1'b0;
  logic [31:0]          result_q, pc_q;
  logic [19:0]          restore_link_q;
  logic [7:0]           current_cpu_priority_q;
  logic                 result_we_q, flags_we_q, pc_we_q, global_int_enable_q;
  logic                 interrupt_control_we_q;
  logic                 overflow_flag_q, sticky_overflow_flag_q, advance_overflow_flag_q;
  logic                 sticky_advance_overflow_flag_q, restore_upper_q, restore_status_word_q;
  logic                 restore_lower_q, call_depth_underflow_trap_q, nesting_error_trap_q;
  int                   failures = 0;
  int                   n_checks = 0;
  int                   cycles = 0;

  accum_exec #(.DEPTH_W(7)) u_dut (
    .clock(clock), .rstn(rstn), .op_valid(op_valid), .op(op), .use_imm(use_imm),
    .short_form(short_form), .imm9_operand(imm9_operand), .src_a(src_a), .src_b(src_b),
    .dest_old(dest_old), .pos1(pos1), .pos2(pos2), .call_depth(call_depth),
    .return_address_reg(return_address_reg), .previous_cpu_priority(previous_cpu_priority),
    .previous_int_enable(previous_int_enable), .context_link_pointer(context_link_pointer),
    .overflow_in(ovf_in), .sticky_overflow_in(sov_in), .advance_overflow_in(aov_in),
    .sticky_advance_in(sadv_in), .result_q(result_q), .result_we_q(result_we_q),
    .flags_we_q(flags_we_q), .overflow_flag_q(overflow_flag_q),
    .sticky_overflow_flag_q(sticky_overflow_flag_q),
    .advance_overflow_flag_q(advance_overflow_flag_q),
    .sticky_advance_overflow_flag_q(sticky_advance_overflow_flag_q),
    .pc_we_q(pc_we_q), .pc_q(pc_q), .restore_upper_q(restore_upper_q),
    .restore_status_word_q(restore_status_word_q), .restore_lower_q(restore_lower_q),
    .restore_link_q(restore_link_q), .interrupt_control_we_q(interrupt_control_we_q),
    .current_cpu_priority_q(current_cpu_priority_q), .global_int_enable_q(global_int_enable_q),
    .call_depth_underflow_trap_q(call_depth_underflow_trap_q),
    .nesting_error_trap_q(nesting_error_trap_q)
  );

  always #50 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Called at a falling edge; request taken at the next rising edge, answer seen one edge on
  task automatic run(input exec_pkg::op_type o);
    op_valid = 1'b1;
    op = o;
    @(posedge clock);
    @(negedge clock);
    op_valid = 1'b0;
    op = exec_pkg::OP_NONE;
  endtask : run

  function automatic logic [31:0] opnd_b(input exec_pkg::op_type o);
    if (!use_imm) return src_b;
    if (o == exec_pkg::OP_ACCUM_ACCUM_SIGNED_A_UNSIGNED || o == exec_pkg::OP_ACCUM_OR_LESS_UNSIGNED ||
        o == exec_pkg::OP_OR_NOT) return {23'h0, imm9_operand};
    return {{23{imm9_operand[8]}}, imm9_operand};
  endfunction : opnd_b

  function automatic logic cmp_ref(input exec_pkg::op_type o, input logic [31:0] b);
    case (o)
      exec_pkg::OP_ACCUM_SIGNED_A:         return $signed(src_a) >= $signed(b);
      exec_pkg::OP_ACCUM_ACCUM_SIGNED_A_UNSIGNED:   return src_a >= b;
      exec_pkg::OP_ACCUM_OR_LESS_SIGNED:   return $signed(src_a) < $signed(b);
      exec_pkg::OP_ACCUM_OR_LESS_UNSIGNED: return src_a < b;
      default:                             return src_a != b;
    endcase
  endfunction : cmp_ref

  task automatic test_accum();
    logic [31:0] a_vals [4] = '{32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0005, 32'h0000_0000};
    logic [31:0] b_vals [4] = '{32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0005, 32'h0000_0000};
    exec_pkg::op_type o;
    logic [31:0] e;
    for (int k = 1; k <= 5; k++) begin
      o = exec_pkg::op_type'(k);
      for (int i = 0; i < 5; i++) begin
        use_imm = (i == 4);
        imm9_operand = 9'h1FF;
        src_a = a_vals[i % 4];
        src_b = b_vals[i % 4];
        dest_old = (i == 3) ? 32'hAAAA_AAAB : 32'h5555_5554;
        e = {dest_old[31:1], dest_old[0] | cmp_ref(o, opnd_b(o))};
        run(o);
        chk(result_q, e, "accum result");
        chk(result_we_q, 1'b1, "accum write");
        chk(flags_we_q, 1'b0, "accum flags");
      end
    end
    $display("test_accum done");
  endtask : test_accum

  task automatic test_logic();
    use_imm = 1'b0;
    src_a = 32'h0000_0080;
    src_b = 32'hFFFF_FDFF;
    for (int i = 0; i < 4; i++) begin
      pos1 = (i[0]) ? 5'h07 : 5'h06;
      pos2 = (i[1]) ? 5'h09 : 5'h1F;
      run(exec_pkg::OP_BIT_OR);
      chk(result_q, {31'h0, src_a[pos1] | src_b[pos2]}, "bit or");
      run(exec_pkg::OP_BIT_OR_NOT);
      chk(result_q, {31'h0, src_a[pos1] | ~src_b[pos2]}, "bit or not");
    end
    src_a = 32'h1200_0001;
    src_b = 32'h0F0F_0F0F;
    run(exec_pkg::OP_OR_NOT);
    chk(result_q, 32'hF2F0_F0F1, "or not reg");
    use_imm = 1'b1;
    imm9_operand = 9'h1FE;
    run(exec_pkg::OP_OR_NOT);
    chk(result_q, 32'hFFFF_FE01, "or not imm");
    chk(flags_we_q, 1'b0, "logic flags");
    $display("test_logic done");
  endtask : test_logic

  task automatic test_returns();
    return_address_reg = 32'h0000_4A10;
    previous_cpu_priority = 8'h3C;
    previous_int_enable = 1'b1;
    call_depth = 7'h00;
    run(exec_pkg::OP_FUNC_RETURN);
    chk(call_depth_underflow_trap_q, 1'b1, "ret trap");
    chk({pc_we_q, restore_upper_q}, 2'b00, "ret trapped state");
    call_depth = 7'h03;
    run(exec_pkg::OP_FUNC_RETURN);
    chk({call_depth_underflow_trap_q, pc_we_q, restore_upper_q}, 3'b011, "ret ok");
    chk(pc_q, 32'h0000_4A10, "ret pc");
    return_address_reg = 32'h0000_7000;
    run(exec_pkg::OP_EXC_RETURN);
    chk(nesting_error_trap_q, 1'b1, "rfe trap");
    chk({pc_we_q, interrupt_control_we_q, restore_upper_q, restore_status_word_q}, 4'h0,
        "rfe held");
    chk(pc_q, 32'h0000_4A10, "rfe pc held");
    chk({current_cpu_priority_q, global_int_enable_q}, 9'h000, "rfe prio held");
    call_depth = 7'h00;
    run(exec_pkg::OP_EXC_RETURN);
    chk({pc_we_q, interrupt_control_we_q, restore_upper_q, restore_status_word_q}, 4'hF,
        "rfe ok");
    chk(nesting_error_trap_q, 1'b0, "rfe no trap");
    chk(pc_q, 32'h0000_7000, "rfe pc");
    chk({current_cpu_priority_q, global_int_enable_q}, {8'h3C, 1'b1}, "rfe priority");
    $display("test_returns done");
  endtask : test_returns

  task automatic test_ctx();
    context_link_pointer = 20'hA5C3E;
    run(exec_pkg::OP_RESTORE_LOWER);
    chk({restore_lower_q, restore_link_q}, {1'b1, 20'hA5C3E}, "restore lower");
    {ovf_in, sov_in, aov_in, sadv_in} = 4'hF;
    run(exec_pkg::OP_RESET_OVERFLOW);
    chk(flags_we_q, 1'b1, "rstv write");
    chk({overflow_flag_q, sticky_overflow_flag_q, advance_overflow_flag_q,
         sticky_advance_overflow_flag_q}, 4'h0, "rstv flags");
    {ovf_in, sov_in, aov_in, sadv_in} = 4'h0;
    $display("test_ctx done");
  endtask : test_ctx

  task automatic rsub_case(input exec_pkg::op_type o, input logic sf, input logic [8:0] im,
                           input logic [31:0] a);
    logic [31:0] m;
    logic [32:0] r;
    logic [31:0] e;
    logic        v;
    m = sf ? 32'h0 : (o == exec_pkg::OP_RSUB_SAT_UNSIGNED) ? {23'h0, im} : {{23{im[8]}}, im};
    r = {1'b0, m} - {1'b0, a};
    e = r[31:0];
    if (o == exec_pkg::OP_RSUB_SAT_UNSIGNED) begin
      v = r[32];
      if (v) e = exec_pkg::SAT_UMIN;
    end else begin
      v = (m[31] != a[31]) && (e[31] != m[31]);
      if (v && o == exec_pkg::OP_RSUB_SAT_SIGNED) begin
        e = m[31] ? exec_pkg::SAT_SMIN : exec_pkg::SAT_SMAX;
      end
    end
    short_form = sf;
    use_imm = 1'b1;
    imm9_operand = im;
    src_a = a;
    run(o);
    chk(result_q, e, "rsub result");
    chk(flags_we_q, 1'b1, "rsub flags write");
    chk({overflow_flag_q, sticky_overflow_flag_q}, {v, v}, "rsub overflow");
    chk({advance_overflow_flag_q, sticky_advance_overflow_flag_q}, {2{e[31] ^ e[30]}},
        "rsub advance");
  endtask : rsub_case

  task automatic test_rsub();
    rsub_case(exec_pkg::OP_RSUB, 1'b0, 9'h1FF, 32'h0000_0001);
    rsub_case(exec_pkg::OP_RSUB, 1'b1, 9'h07E, 32'h8000_0000);
    rsub_case(exec_pkg::OP_RSUB, 1'b1, 9'h07E, 32'h0000_0003);
    rsub_case(exec_pkg::OP_RSUB_SAT_SIGNED, 1'b0, 9'h0FF, 32'h8000_0000);
    rsub_case(exec_pkg::OP_RSUB_SAT_SIGNED, 1'b0, 9'h100, 32'h7FFF_FFFF);
    rsub_case(exec_pkg::OP_RSUB_SAT_UNSIGNED, 1'b0, 9'h005, 32'h0000_0006);
    rsub_case(exec_pkg::OP_RSUB_SAT_UNSIGNED, 1'b0, 9'h1FF, 32'h0000_0001);
    short_form = 1'b0;
    $display("test_rsub done");
  endtask : test_rsub

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20) @(negedge clock);
    chk(result_q, exec_pkg::RESULT_RESET, "reset result");
    rstn = 1'b1;
    @(negedge clock);
    test_accum();
    test_logic();
    test_returns();
    test_ctx();
    test_rsub();
    complete_run();
  end
endmodule : tb
`default_nettype wire
